/* common/mode_switch_pkg.sv */
/*
 * package for the analog mode switch block: register map, field layout,
 * reset values, variant and mode encodings, bus carrier struct.
 * assumes a 32-bit apb master and a single 50 MHz clock.
 */
// Notes on behaviour
// (R1) selector 0 requests normal conversion; selector 1 requests calibration mode.
// (R2) any selector other than 0 or 1 means calibration mode.
// (R3) host names the module by start i/o number 00h to feh.
// (R4) calibration status flag rises on entry to calibration mode.
// (R5) calibration status flag falls on return to normal mode.
// (R6) ready flag goes high to low when entering calibration mode.
// (R7) ready flag goes low to high on return to normal mode.
// (R8) a/d and temperature variants resume with prior operating conditions; here active_cond reloads from cond_r one cycle after return.
// (R9) d/a variants disable every channel on return to normal mode.
// (R10) host re-enables d/a channels with 0, then pulses update request.
// (R11) requests refused while module is a synchronization target.
// (R12) high-speed a/d refuses in highest-speed or simultaneous mode.
// (R13) d/a refuses while waveform output mode is selected.
// (R14) high-speed d/a refuses while high-speed output mode is selected.
// (R15) a refused request leaves mode, status and ready flags unchanged.
package mode_switch_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_REQ = 8'h00;      // write: selector and start i/o
    localparam logic [7:0] OFS_STATUS = 8'h04;   // read: flags
    localparam logic [7:0] OFS_CONFIG = 8'h08;   // variant and sub-mode selection
    localparam logic [7:0] OFS_CHAN_DIS = 8'h0c; // channel disable bits
    localparam logic [7:0] OFS_COND = 8'h10;     // operating conditions
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14; // sticky events, write 1 clears
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18; // 1 enables the event

    // field positions
    localparam int REQ_SEL_LSB = 0;   // 16-bit selector
    localparam int REQ_IO_LSB = 16;   // 8-bit start i/o number
    localparam int ST_CALIB = 0;
    localparam int ST_READY = 1;
    localparam int ST_ACTIVE = 2;
    localparam int CFG_VAR_LSB = 0;   // 3-bit variant
    localparam int CFG_SYNC = 4;
    localparam int CFG_HS_MODE = 5;
    localparam int CFG_SIMUL = 6;
    localparam int CFG_WAVE = 7;
    localparam int CFG_HS_OUT = 8;
    localparam int CFG_UPDATE = 9;    // operating condition update request
    localparam int CFG_IO_LSB = 16;   // own start i/o number

    // interrupt event bits
    localparam int EV_ENTER = 0;
    localparam int EV_LEAVE = 1;
    localparam int EV_REFUSE = 2;
    localparam int EV_BAD_IO = 3;
    localparam int EV_W = 4;

    localparam int NUM_CH = 8;
    localparam logic [7:0] IO_MAX = 8'hfe;
    localparam logic [15:0] SEL_NORMAL = 16'h0000;
    localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
    localparam logic [NUM_CH-1:0] CHAN_DIS_RST = 8'h00;
    localparam logic [31:0] COND_RST = 32'h0000_0000;

    typedef enum logic [2:0] {
        VAR_AD = 3'h0,
        VAR_AD_HS = 3'h1,
        VAR_TEMP = 3'h2,
        VAR_DA = 3'h3,
        VAR_DA_HS = 3'h4
    } variant_e;

    // apb request carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

endpackage

/* rtl/mode_refuse_check.sv */
/*
 * refusal decision for a mode switch request from variant and sub-modes.
 * assumes configuration bits come from registers on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module mode_refuse_check
    import mode_switch_pkg::*;
(
    input wire logic [2:0] variant,
    input wire logic sync_target,
    input wire logic hs_mode,
    input wire logic simul_mode,
    input wire logic wave_mode,
    input wire logic hs_out_mode,
    output logic refuse
);
    // any blocking condition for this variant refuses the request
    always_comb begin
        refuse = sync_target; // R11
        if (variant == VAR_AD_HS && (hs_mode || simul_mode)) begin
            refuse = 1'b1; // R12
        end
        if ((variant == VAR_DA || variant == VAR_DA_HS) && wave_mode) begin
            refuse = 1'b1; // R13
        end
        if (variant == VAR_DA_HS && hs_out_mode) begin
            refuse = 1'b1; // R14
        end
    end
endmodule
`default_nettype wire

/* rtl/sticky_event_bit.sv */
/*
 * one sticky interrupt status bit: set by event, cleared by write one.
 * assumes event and clear are on the same clock; set wins over clear.
 */
`timescale 1ns/1ns
`default_nettype none
module sticky_event_bit (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic set_pulse,
    input wire logic clr_pulse,
    output logic flag_r
);
    // set beats a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_r <= 1'b0;
        end else if (set_pulse) begin
            flag_r <= 1'b1;
        end else if (clr_pulse) begin
            flag_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* rtl/analog_mode_switch.sv */
/*
 * analog module mode switch: apb register file, normal/calibration mode
 * state, status and ready flags, channel disable on d/a return, saved
 * operating conditions, refusal logic and interrupt.
 * assumes one 50 MHz clock, asynchronous active-low reset, apb master
 * on the same clock; pready is always high, so every access has no wait.
 */
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module analog_mode_switch
    import mode_switch_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic calib_mode_status_flag,
    output logic module_ready_flag,
    output logic op_condition_update_request,
    output logic [NUM_CH-1:0] chan_disable,
    output logic [31:0] active_cond,
    output logic irq
);
    typedef enum logic {
        MODE_NORMAL,
        MODE_CALIB
    } mode_e;

    mode_e mode_r;
    logic [31:0] config_r;
    logic [NUM_CH-1:0] chan_dis_r;
    logic [31:0] cond_r;
    logic [31:0] saved_cond_r;
    logic [EV_W-1:0] mask_r;
    logic [EV_W-1:0] ev_stat;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [31:0] prdata_r;
    logic calib_r;
    logic ready_r;
    logic refuse;
    logic wr_en;
    logic rd_en;
    logic req_wr;
    logic [15:0] req_sel;
    logic [7:0] req_io;
    logic io_match;
    logic want_calib;
    logic accept;
    logic do_enter;
    logic do_leave;
    logic addr_ok;
    logic is_da;

    // apb access phase decode; slave never inserts wait states
    assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
    assign rd_en = apb_req.psel && apb_req.penable && !apb_req.pwrite;
    assign pready = 1'b1;
    always_comb begin
        unique case (apb_req.paddr)
            OFS_REQ, OFS_STATUS, OFS_CONFIG, OFS_CHAN_DIS,
            OFS_COND, OFS_IRQ_STAT, OFS_IRQ_MASK: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = apb_req.psel && apb_req.penable && !addr_ok;

    // mode request fields
    assign req_wr = wr_en && apb_req.paddr == OFS_REQ;
    assign req_sel = apb_req.pwdata[REQ_SEL_LSB +: 16];
    assign req_io = apb_req.pwdata[REQ_IO_LSB +: 8];
    // host must name a legal start i/o that matches this module
    assign io_match = req_io <= IO_MAX && req_io == config_r[CFG_IO_LSB +: 8]; // R3
    // zero selects normal, every other value selects calibration
    assign want_calib = req_sel != SEL_NORMAL; // R1 R2
    assign is_da = config_r[CFG_VAR_LSB +: 3] == VAR_DA
        || config_r[CFG_VAR_LSB +: 3] == VAR_DA_HS;

    mode_refuse_check u_refuse (
        .variant(config_r[CFG_VAR_LSB +: 3]),
        .sync_target(config_r[CFG_SYNC]),
        .hs_mode(config_r[CFG_HS_MODE]),
        .simul_mode(config_r[CFG_SIMUL]),
        .wave_mode(config_r[CFG_WAVE]),
        .hs_out_mode(config_r[CFG_HS_OUT]),
        .refuse(refuse)
    );

    assign accept = req_wr && io_match && !refuse; // R15
    assign do_enter = accept && want_calib && mode_r == MODE_NORMAL;
    assign do_leave = accept && !want_calib && mode_r == MODE_CALIB;

    // mode state
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= MODE_NORMAL;
        end else if (do_enter) begin
            mode_r <= MODE_CALIB;
        end else if (do_leave) begin
            mode_r <= MODE_NORMAL;
        end
    end

    // calibration status flag
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            calib_r <= 1'b0;
        end else if (do_enter) begin
            calib_r <= 1'b1; // R4
        end else if (do_leave) begin
            calib_r <= 1'b0; // R5
        end
    end

    // module ready flag, high in normal mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_r <= 1'b1;
        end else if (do_enter) begin
            ready_r <= 1'b0; // R6
        end else if (do_leave) begin
            ready_r <= 1'b1; // R7
        end
    end

    // configuration register, includes the update request bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            config_r <= CONFIG_RST;
        end else if (wr_en && apb_req.paddr == OFS_CONFIG) begin
            config_r <= apb_req.pwdata;
        end
    end

    // channel disable bits; d/a return disables all channels
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chan_dis_r <= CHAN_DIS_RST;
        end else if (do_leave && is_da) begin
            chan_dis_r <= '1; // R9
        end else if (wr_en && apb_req.paddr == OFS_CHAN_DIS) begin
            chan_dis_r <= apb_req.pwdata[NUM_CH-1:0]; // R10
        end
    end

    // operating conditions as written by software
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cond_r <= COND_RST;
        end else if (wr_en && apb_req.paddr == OFS_COND) begin
            cond_r <= apb_req.pwdata;
        end
    end

    // conditions in force: frozen on entry, held through the return edge, then reloaded from cond_r
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            saved_cond_r <= COND_RST;
        end else if (mode_r == MODE_NORMAL && !do_enter) begin
            saved_cond_r <= cond_r; // R8
        end
    end

    // interrupt events
    assign ev_set[EV_ENTER] = do_enter;
    assign ev_set[EV_LEAVE] = do_leave;
    assign ev_set[EV_REFUSE] = req_wr && io_match && refuse;
    assign ev_set[EV_BAD_IO] = req_wr && !io_match;
    assign ev_clr = (wr_en && apb_req.paddr == OFS_IRQ_STAT)
        ? apb_req.pwdata[EV_W-1:0] : '0;

    generate
        for (genvar i = 0; i < EV_W; i++) begin : g_ev
            sticky_event_bit u_bit (
                .ref_clk(ref_clk),
                .rst_n(rst_n),
                .set_pulse(ev_set[i]),
                .clr_pulse(ev_clr[i]),
                .flag_r(ev_stat[i])
            );
        end
    endgenerate

    // interrupt mask
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= '0;
        end else if (wr_en && apb_req.paddr == OFS_IRQ_MASK) begin
            mask_r <= apb_req.pwdata[EV_W-1:0];
        end
    end

    // read data, registered in setup phase so it is valid in access phase
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_r <= '0;
        end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
            unique case (apb_req.paddr)
                OFS_STATUS: prdata_r <= {29'h0, mode_r == MODE_CALIB, ready_r, calib_r};
                OFS_CONFIG: prdata_r <= config_r;
                OFS_CHAN_DIS: prdata_r <= {24'h0, chan_dis_r};
                OFS_COND: prdata_r <= cond_r;
                OFS_IRQ_STAT: prdata_r <= {28'h0, ev_stat};
                OFS_IRQ_MASK: prdata_r <= {28'h0, mask_r};
                default: prdata_r <= '0;
            endcase
        end
    end

    assign prdata = rd_en ? prdata_r : '0;
    assign calib_mode_status_flag = calib_r;
    assign module_ready_flag = ready_r;
    assign op_condition_update_request = config_r[CFG_UPDATE];
    assign chan_disable = chan_dis_r;
    assign active_cond = saved_cond_r;
    assign irq = |(ev_stat & mask_r);

    property p_enter;
        @(posedge ref_clk) disable iff (!rst_n)
        do_enter |=> calib_r && !ready_r && mode_r == MODE_CALIB;
    endproperty
    a_enter: assert property (p_enter) else $error("entry flags wrong"); // R4

    property p_ready_low;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(ready_r) |-> $past(mode_r) == MODE_NORMAL && $past(want_calib);
    endproperty
    a_ready_low: assert property (p_ready_low) else $error("ready fell wrongly"); // R6

    property p_leave;
        @(posedge ref_clk) disable iff (!rst_n)
        do_leave |=> !calib_r && ready_r && mode_r == MODE_NORMAL;
    endproperty
    a_leave: assert property (p_leave) else $error("return flags wrong"); // R5

    property p_ready_high;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(ready_r) |-> $past(req_sel) == SEL_NORMAL && !calib_r;
    endproperty
    a_ready_high: assert property (p_ready_high) else $error("ready rose wrongly"); // R7

    property p_sel;
        @(posedge ref_clk) disable iff (!rst_n)
        (accept && req_sel > 16'h0001 && mode_r == MODE_NORMAL) |=> calib_r;
    endproperty
    a_sel: assert property (p_sel) else $error("odd selector ignored"); // R2

    property p_refuse;
        @(posedge ref_clk) disable iff (!rst_n)
        (req_wr && refuse) |=> $stable(mode_r) && $stable(calib_r) && $stable(ready_r);
    endproperty
    a_refuse: assert property (p_refuse) else $error("refused request acted"); // R15

    property p_sync;
        @(posedge ref_clk) disable iff (!rst_n)
        config_r[CFG_SYNC] |-> refuse;
    endproperty
    a_sync: assert property (p_sync) else $error("sync target not refused"); // R11

    property p_da_off;
        @(posedge ref_clk) disable iff (!rst_n)
        (do_leave && is_da) |=> chan_dis_r == '1 && ev_stat[EV_LEAVE];
    endproperty
    a_da_off: assert property (p_da_off) else $error("channels not disabled"); // R9

    property p_cond;
        @(posedge ref_clk) disable iff (!rst_n)
        (mode_r == MODE_CALIB) |=> $stable(saved_cond_r) || mode_r == MODE_NORMAL;
    endproperty
    a_cond: assert property (p_cond) else $error("conditions lost in calibration"); // R8

    property p_wave;
        @(posedge ref_clk) disable iff (!rst_n)
        (is_da && config_r[CFG_WAVE]) |-> refuse;
    endproperty
    a_wave: assert property (p_wave) else $error("wave mode not refused"); // R13

    // flags track the mode, and only an accepted request word moves it
    property p_flags_mirror;
        @(posedge ref_clk) disable iff (!rst_n)
        calib_r == (mode_r == MODE_CALIB) && ready_r == (mode_r == MODE_NORMAL);
    endproperty
    a_flags_mirror: assert property (p_flags_mirror) else $error("flags off mode"); // R4 R6

    property p_quiet;
        @(posedge ref_clk) disable iff (!rst_n)
        !req_wr |=> $stable(mode_r);
    endproperty
    a_quiet: assert property (p_quiet) else $error("mode moved without request"); // R1

    property p_sel_zero;
        @(posedge ref_clk) disable iff (!rst_n)
        (accept && req_sel == SEL_NORMAL && mode_r == MODE_CALIB) |=> mode_r == MODE_NORMAL;
    endproperty
    a_sel_zero: assert property (p_sel_zero) else $error("selector zero ignored"); // R1

    property p_sel_one;
        @(posedge ref_clk) disable iff (!rst_n)
        (accept && req_sel == 16'h0001 && mode_r == MODE_NORMAL) |=> mode_r == MODE_CALIB;
    endproperty
    a_sel_one: assert property (p_sel_one) else $error("selector one ignored"); // R1

    // refusal conditions of the fast variants
    property p_hs_ad;
        @(posedge ref_clk) disable iff (!rst_n)
        (config_r[CFG_VAR_LSB +: 3] == VAR_AD_HS
            && (config_r[CFG_HS_MODE] || config_r[CFG_SIMUL])) |-> refuse;
    endproperty
    a_hs_ad: assert property (p_hs_ad) else $error("fast a/d mode not refused"); // R12

    property p_hs_out;
        @(posedge ref_clk) disable iff (!rst_n)
        (config_r[CFG_VAR_LSB +: 3] == VAR_DA_HS && config_r[CFG_HS_OUT]) |-> refuse;
    endproperty
    a_hs_out: assert property (p_hs_out) else $error("fast output not refused"); // R14

    property p_fast_wave;
        @(posedge ref_clk) disable iff (!rst_n)
        (config_r[CFG_VAR_LSB +: 3] == VAR_DA_HS && config_r[CFG_WAVE]) |-> refuse;
    endproperty
    a_fast_wave: assert property (p_fast_wave) else $error("fast d/a wave not refused"); // R13

    // refused or misaddressed requests leave the mode alone but are reported
    property p_bad_io;
        @(posedge ref_clk) disable iff (!rst_n)
        (req_wr && !io_match) |=> $stable(mode_r) && $stable(calib_r) && $stable(ready_r);
    endproperty
    a_bad_io: assert property (p_bad_io) else $error("misaddressed request acted"); // R15

    property p_refuse_event;
        @(posedge ref_clk) disable iff (!rst_n)
        (req_wr && io_match && refuse) |=> ev_stat[EV_REFUSE];
    endproperty
    a_refuse_event: assert property (p_refuse_event) else $error("no refuse event"); // R15

    // a/d and temperature returns keep channels and conditions
    property p_keep_chan;
        @(posedge ref_clk) disable iff (!rst_n)
        (do_leave && !is_da) |=> $stable(chan_dis_r);
    endproperty
    a_keep_chan: assert property (p_keep_chan) else $error("a/d channels changed"); // R8

    property p_cond_return;
        @(posedge ref_clk) disable iff (!rst_n)
        do_leave |=> $stable(saved_cond_r);
    endproperty
    a_cond_return: assert property (p_cond_return) else $error("conditions not resumed"); // R8

endmodule
`default_nettype wire

/* bench/apb_host.sv */
/*
 * host controller model: apb master issuing register accesses and mode requests.
 * assumes pready, prdata and pslverr come from the device on ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module apb_host
    import mode_switch_pkg::*;
(
    input wire logic ref_clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output var apb_req_s apb_req
);
    logic last_err;

    // idle bus from time zero
    initial begin
        apb_req = '0;
        last_err = 1'b0;
    end

    // one apb transfer: setup, then access held until pready
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge ref_clk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        q = prdata;
        last_err = pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        apb_req.pwdata <= ~d; // released data no longer shows the last value
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, q);
    endtask

    // mode request: module named by start i/o within 00h..feh
    task automatic req(input logic [15:0] sel, input logic [7:0] io);
        logic [7:0] io_ok;
        io_ok = (io > IO_MAX) ? IO_MAX : io;
        wr(OFS_REQ, {8'h00, io_ok, sel});
    endtask
endmodule
`default_nettype wire

/* bench/analog_mode_switch_tb_top.sv */
/*
 * testbench for the analog mode switch: register sequences through the host model.
 * assumes the package constants and a zero-wait apb slave.
 */
`timescale 1ns/1ns
`default_nettype none
module analog_mode_switch_tb_top;
    import mode_switch_pkg::*;
    logic ref_clk, rst_n, pready, pslverr, calib, ready, upd, irq;
    apb_req_s apb_req;
    logic [31:0] prdata, active_cond, q;
    logic [NUM_CH-1:0] chan_disable;
    logic [31:0] refuse_cfg [5];
    int mismatches = 0;
    int checks = 0;

    analog_mode_switch analog_mode_switch_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .calib_mode_status_flag(calib), .module_ready_flag(ready),
        .op_condition_update_request(upd), .chan_disable(chan_disable),
        .active_cond(active_cond), .irq(irq));
    apb_host apb_host_i (.ref_clk(ref_clk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .apb_req(apb_req));

    // 50 mhz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // let the flag update edge land
    task automatic settle();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic mode(input logic [15:0] sel, input logic [7:0] io);
        apb_host_i.req(sel, io);
        settle();
    endtask

    // watchdog
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end

    // main sequence
    initial begin
        rst_n = 1'b0;
        refuse_cfg = '{32'h0012_0010, 32'h0012_0021, 32'h0012_0041, 32'h0012_0083,
                       32'h0012_0104};
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        settle();
        check({calib, ready}, 2'b01);
        apb_host_i.rd(OFS_STATUS, q);
        check(q[1:0], 2'b10);
        apb_host_i.wr(OFS_IRQ_MASK, 32'h0000_000f);
        apb_host_i.wr(OFS_CONFIG, 32'h0012_0000);
        apb_host_i.wr(OFS_COND, 32'h0000_0055);
        mode(16'h0001, 8'h12);
        check({calib, ready}, 2'b10);
        apb_host_i.wr(OFS_COND, 32'h0000_00aa);
        settle();
        check(active_cond, 32'h0000_0055);
        apb_host_i.wr(OFS_COND, 32'h0000_0055);
        mode(16'h0000, 8'h12);
        check({calib, ready}, 2'b01);
        check(active_cond, 32'h0000_0055);
        mode(16'h0005, 8'h12);
        check({calib, ready}, 2'b10);
        mode(16'h0000, 8'h12);
        check({calib, ready}, 2'b01);
        mode(16'hffff, 8'h12);
        check({calib, ready}, 2'b10);
        mode(16'h0000, 8'h12);
        // sub-mode bits that do not apply to a plain a/d variant
        apb_host_i.wr(OFS_CONFIG, 32'h0012_01e0);
        mode(16'h0001, 8'h12);
        check({calib, ready}, 2'b10);
        mode(16'h0000, 8'h12);
        check({calib, ready}, 2'b01);
        apb_host_i.rd(OFS_IRQ_STAT, q);
        check(q[3:0], 4'h3);
        check(irq, 1'b1);
        apb_host_i.wr(OFS_IRQ_STAT, 32'h0000_0003);
        settle();
        check(irq, 1'b0);
        // each refusing sub-mode, one after another
        for (int i = 0; i < 5; i++) begin
            apb_host_i.wr(OFS_CONFIG, refuse_cfg[i]);
            mode(16'h0001, 8'h12);
            check({calib, ready}, 2'b01);
            apb_host_i.rd(OFS_IRQ_STAT, q);
            check(q[3:0], 4'h4);
            check(irq, 1'b1);
            apb_host_i.wr(OFS_IRQ_STAT, 32'h0000_0004);
            settle();
            check(irq, 1'b0);
        end
        // masked event: status sets, irq stays low
        apb_host_i.wr(OFS_CONFIG, 32'h0012_0003);
        apb_host_i.wr(OFS_IRQ_MASK, 32'h0000_0000);
        mode(16'h0001, 8'h13);
        check({calib, ready, irq}, 3'b010);
        apb_host_i.rd(OFS_IRQ_STAT, q);
        check(q[3:0], 4'h8);
        apb_host_i.wr(OFS_IRQ_STAT, 32'h0000_0008);
        apb_host_i.wr(OFS_IRQ_MASK, 32'h0000_000f);
        apb_host_i.wr(OFS_REQ, 32'h00ff_0001);
        settle();
        check({calib, ready, irq}, 3'b011);
        apb_host_i.wr(OFS_IRQ_STAT, 32'h0000_000f);
        // d/a return disables every channel
        apb_host_i.wr(OFS_CHAN_DIS, 32'h0000_0000);
        mode(16'h0001, 8'h12);
        check({calib, ready}, 2'b10);
        mode(16'h0000, 8'h12);
        check({calib, ready}, 2'b01);
        check(chan_disable, 8'hff);
        // host restart of d/a output
        apb_host_i.wr(OFS_CHAN_DIS, 32'h0000_0000);
        apb_host_i.wr(OFS_CONFIG, 32'h0012_0203);
        settle();
        check(upd, 1'b1);
        apb_host_i.wr(OFS_CONFIG, 32'h0012_0003);
        settle();
        check({upd, chan_disable}, 9'h000);
        // unmapped address
        apb_host_i.rd(8'h40, q);
        check(apb_host_i.last_err, 1'b1);
        apb_host_i.rd(OFS_STATUS, q);
        check(apb_host_i.last_err, 1'b0);
        report_and_stop();
    end
endmodule
`default_nettype wire
